// [common/sfp_pkg.sv]
// Constants, types and register map of the FIFO synchronous serial port.
`default_nettype none
package sfp_pkg;
  localparam int unsigned AW        = 4;
  localparam int unsigned DEPTH     = 32;
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_FCON   = 4'h4;
  localparam logic [3:0] OFS_RX     = 4'h8;
  localparam logic [3:0] OFS_TX     = 4'hc;
  localparam logic [7:0] CTRL_RST   = 8'h80;
  localparam logic [7:0] FCON_RST   = 8'h11;
  localparam int unsigned F_EMP     = 0;
  localparam int unsigned F_FUL     = 1;
  localparam int unsigned F_ORE     = 2;
  localparam int unsigned F_INIT    = 3;
  localparam int unsigned F_CINIT   = 7;
  localparam logic [1:0] GAP_HALVES = 2'h2;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;

  // Control register image; the two top fields are never stored.
  typedef struct packed {
    logic       one;
    logic       busy;
    logic       ick;
    logic       ten;
    logic       role;
    logic [2:0] src;
  } sfp_ctrl_t;

  typedef struct packed {
    logic transfer_clock_pin_o;
    logic transfer_clock_pin_oe;
    logic serial_out_pin;
  } sfp_pins_t;

  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SHIFT, ST_GAP} sfp_state_t;
endpackage
`default_nettype wire

// [verification/fifo_sync_serial_port_bench.sv]
// Self-checking bench of the FIFO synchronous serial port.
`default_nettype none
module fifo_sync_serial_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic               sys_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               core_reset_event = 1'b0;
  logic               tbc_tick = 1'b0;
  logic               tmr_ovf_tick = 1'b0;
  logic [2:0]         tick_cnt = 3'h0;
  logic [3:0]         awaddr = 4'h0;
  logic [3:0]         araddr = 4'h0;
  logic [31:0]        wdata = 32'h0;
  logic               awvalid = 1'b0;
  logic               wvalid = 1'b0;
  logic               bready = 1'b0;
  logic               arvalid = 1'b0;
  logic               rready = 1'b0;
  logic               c_empty = 1'b1;
  logic               c_full = 1'b0;
  logic               c_ovr = 1'b0;
  logic               awready, wready, bvalid, arready, rvalid, done, c_init, miso, clk_drv;
  logic [1:0]         bresp, rresp;
  logic [31:0]        rdata;
  sfp_pkg::sfp_pins_t pins;
  wire logic          clk_line;
  int                 failures = 0;
  int                 n_compared = 0;
  int                 n_done = 0;
  int                 n_cinit = 0;
  int                 cycles = 0;

  // Free-running clock; the pin level resolves the two possible drivers.
  always #10 sys_clk = ~sys_clk;
  assign clk_line = pins.transfer_clock_pin_oe ? pins.transfer_clock_pin_o : clk_drv;

  sfp_serial_port u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .core_reset_event(core_reset_event),
    .tbc_tick(tbc_tick), .tmr_ovf_tick(tmr_ovf_tick), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .transfer_clock_pin_i(clk_line),
    .serial_in_pin(miso), .pins(pins), .xfer_done(done), .companion_empty_flag(c_empty),
    .companion_full_flag(c_full), .companion_overrun_flag(c_ovr), .companion_initialise(c_init));

  sfp_peer_model u_peer (.clk_line(clk_line), .mosi(pins.serial_out_pin), .miso(miso), .clk_drv(clk_drv));

  // Clock-source ticks, pulse counters and the hang limit.
  always @(posedge sys_clk)
  begin
    tick_cnt <= tick_cnt + 3'h1;
    tbc_tick <= (tick_cnt[1:0] == 2'h3);
    tmr_ovf_tick <= (tick_cnt == 3'h7);
    n_done <= n_done + ((done === 1'b1) ? 1 : 0);
    n_cinit <= n_cinit + ((c_init === 1'b1) ? 1 : 0);
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      failures++;
      give_verdict;
    end
  end

  task automatic give_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Ready is judged at the falling edge, so the value used is the one the next rising edge samples.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bit aw_hit, w_hit, aw_done, w_done;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_done = 0;
    w_done = 0;
    while (!(aw_done && w_done))
    begin
      @(negedge sys_clk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      @(posedge sys_clk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      aw_done |= aw_hit;
      w_done |= w_hit;
    end
    do @(negedge sys_clk); while (bvalid !== 1'b1);
    check("write response", 32'(bresp), 32'(sfp_pkg::RESP_OKAY));
    @(posedge sys_clk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    bit hit;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hit = 0;
    while (!hit)
    begin
      @(negedge sys_clk);
      hit = arready;
      @(posedge sys_clk);
    end
    arvalid <= 1'b0;
    do @(negedge sys_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge sys_clk);
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string what);
    logic [31:0] v;
    logic [1:0]  r;
    rd(a, v, r);
    check(what, v, {24'h0, exp});
  endtask

  // Two-byte exchange; the bench keeps off the data registers while busy.
  task automatic xchg(input logic [7:0] cfg, input logic [7:0] base);
    int d0;
    u_peer.reset_frame(base);
    for (int i = 0; i < 2; i++)
      wr(sfp_pkg::OFS_TX, ~base + 8'(i));
    wr(sfp_pkg::OFS_CTRL, cfg);
    check("clock pin enable", 32'(pins.transfer_clock_pin_oe), 32'(!cfg[3]));
    d0 = n_done;
    wr(sfp_pkg::OFS_CTRL, cfg | 8'h10);
    rchk(sfp_pkg::OFS_CTRL, {2'b11, cfg[5:0]} | 8'h10, "busy control");
    if (cfg[3])
      u_peer.run_clocks(16);
    while (n_done == d0)
      @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    check("done pulses", n_done, d0 + 1);
    rchk(sfp_pkg::OFS_CTRL, {2'b10, cfg[5:0]}, "enable self clear");
    for (int i = 0; i < 2; i++)
    begin
      check("peer byte", u_peer.rx_log[i], 8'(~base + 8'(i)));
      rchk(sfp_pkg::OFS_RX, base + 8'(i), "received byte");
    end
    rchk(sfp_pkg::OFS_FCON, 8'h11, "empty after readout");
  endtask

  // Main sequence.
  initial
  begin
    logic [31:0] v;
    logic [1:0]  r;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rchk(sfp_pkg::OFS_CTRL, 8'h80, "control reset");
    rchk(sfp_pkg::OFS_FCON, 8'h11, "fifo control reset");
    wr(sfp_pkg::OFS_CTRL, 8'h6f);
    rchk(sfp_pkg::OFS_CTRL, 8'haf, "control top bits");
    wr(sfp_pkg::OFS_FCON, 8'h33);
    rchk(sfp_pkg::OFS_FCON, 8'h11, "status read only");
    rd(4'h2, v, r);
    check("unmapped response", 32'(r), 32'(sfp_pkg::RESP_SLV));
    for (int k = 0; k < 8; k++)
      xchg({2'b00, 1'(k), 2'b00, 3'(k)}, 8'h40 + 8'(k * 8));
    xchg(8'h2f, 8'hc0);
    u_peer.run_clocks(1);
    repeat (8) @(posedge sys_clk);
    rchk(sfp_pkg::OFS_FCON, 8'h15, "overrun");
    wr(sfp_pkg::OFS_FCON, 8'h08);
    rchk(sfp_pkg::OFS_FCON, 8'h11, "initialise");
    wr(sfp_pkg::OFS_CTRL, 8'h00);
    c_full <= 1'b1;
    c_ovr <= 1'b1;
    v = n_cinit;
    wr(sfp_pkg::OFS_FCON, 8'h80);
    rchk(sfp_pkg::OFS_FCON, 8'h71, "companion flags");
    check("companion init", n_cinit, v + 1);
    c_full <= 1'b0;
    c_ovr <= 1'b0;
    for (int i = 0; i < 32; i++)
      wr(sfp_pkg::OFS_TX, 8'(i));
    rchk(sfp_pkg::OFS_FCON, 8'h12, "full");
    wr(sfp_pkg::OFS_CTRL, 8'h06);
    v = n_done;
    wr(sfp_pkg::OFS_CTRL, 8'h16);
    repeat (40) @(posedge sys_clk);
    wr(sfp_pkg::OFS_CTRL, 8'h06);
    rchk(sfp_pkg::OFS_FCON, 8'h11, "abort empties");
    rchk(sfp_pkg::OFS_CTRL, 8'h86, "abort idle");
    check("no done on abort", n_done, v);
    wr(sfp_pkg::OFS_TX, 8'h55);
    wr(sfp_pkg::OFS_CTRL, 8'h2f);
    core_reset_event <= 1'b1;
    @(posedge sys_clk);
    core_reset_event <= 1'b0;
    rchk(sfp_pkg::OFS_CTRL, 8'h80, "core reset");
    rchk(sfp_pkg::OFS_FCON, 8'h11, "core reset fifo");
    give_verdict;
  end
endmodule
`default_nettype wire

// [verification/sfp_peer_model.sv]
// Behavioural model of the far serial device on the transfer clock pin.
`default_nettype none
module sfp_peer_model (
  input  wire logic clk_line,
  input  wire logic mosi,
  output var logic  miso,
  output var logic  clk_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_log [0:31];
  logic [7:0] rx_sr;
  logic [7:0] base;
  int         bits;

  // New frame; the data line is toggled so a stale level is never mistaken for data.
  task automatic reset_frame(input logic [7:0] b);
    base = b;
    bits = 0;
    miso = ~miso;
  endtask

  // Slave clock runs inside frames and once after one for the overrun check, 160 ns period, idle high, kept off system clock edges.
  task automatic run_clocks(input int n);
    #5;
    repeat (n)
    begin
      #80 clk_drv = 1'b0;
      #80 clk_drv = 1'b1;
    end
  endtask

  // Idle levels at start.
  initial
  begin
    clk_drv = 1'b1;
    miso = 1'b1;
    bits = 0;
    base = 8'h00;
  end

  always @(negedge clk_line)
    miso = 1'(8'(base + 8'(bits / 8)) >> (bits % 8));

  always @(posedge clk_line)
  begin
    rx_sr = {mosi, rx_sr[7:1]};
    if (bits % 8 == 7 && bits < 256)
      rx_log[bits / 8] = rx_sr;
    bits = bits + 1;
  end
endmodule
`default_nettype wire

// [verilog/sfp_fifo.sv]
// Shared 32-byte FIFO that holds transmit bytes and then their replies.
`default_nettype none
module sfp_fifo (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clr,
  input  wire logic       push,
  input  wire logic [7:0] wdata,
  input  wire logic       pop,
  output logic      [7:0] rdata,
  output logic      [5:0] count,
  output logic            empty,
  output logic            full
);
  logic [7:0] mem_reg [sfp_pkg::DEPTH];
  logic [4:0] wp_reg;
  logic [4:0] rp_reg;
  logic [5:0] cnt_reg;
  logic       do_push;
  logic       do_pop;

  // A push into a full FIFO or a pop from an empty one is dropped.
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;
  assign count   = cnt_reg;
  assign empty   = (cnt_reg == 6'h00);
  assign full    = (cnt_reg == 6'(sfp_pkg::DEPTH));
  assign rdata   = mem_reg[rp_reg];

  // Pointers wrap naturally at the power-of-two depth.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || clr)
    begin
      wp_reg  <= 5'h00;
      rp_reg  <= 5'h00;
      cnt_reg <= 6'h00;
    end
    else
    begin
      if (do_push)
        wp_reg <= wp_reg + 5'h01;
      if (do_pop)
        rp_reg <= rp_reg + 5'h01;
      cnt_reg <= cnt_reg + 6'(do_push) - 6'(do_pop);
    end
  end

  // Storage needs no reset; contents after reset are undefined.
  for (genvar i = 0; i < sfp_pkg::DEPTH; i++)
  begin : g_ent
    always_ff @(posedge sys_clk)
    begin
      if (do_push && wp_reg == 5'(i))
        mem_reg[i] <= wdata;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  full_flag_a: assert property (cnt_reg == 6'h1f && do_push && !do_pop |=> full && !empty)
    else $error("Full flag does not match 32 bytes.");
  clr_empty_a: assert property (clr |=> empty)
    else $error("FIFO not empty after clear.");
endmodule
`default_nettype wire

// [verilog/sfp_serial_port.sv]
// FIFO synchronous serial port: AXI4-Lite registers, clocking and shifter.
`default_nettype none
module sfp_serial_port (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          core_reset_event,
  input  wire logic          tbc_tick,
  input  wire logic          tmr_ovf_tick,
  input  wire logic [3:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [3:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          transfer_clock_pin_i,
  input  wire logic          serial_in_pin,
  output sfp_pkg::sfp_pins_t pins,
  output logic               xfer_done,
  input  wire logic          companion_empty_flag,
  input  wire logic          companion_full_flag,
  input  wire logic          companion_overrun_flag,
  output logic               companion_initialise
);
  sfp_pkg::sfp_state_t state_reg;
  sfp_pkg::sfp_ctrl_t  ctrl_rd;
  sfp_pkg::sfp_ctrl_t  ctl_wd;
  logic [2:0] src_reg;
  logic       role_reg;
  logic       ten_reg;
  logic       ick_reg;
  logic       ovr_reg;
  logic       slv_done_reg;
  logic       done_reg;
  logic       cinit_reg;
  logic       sck_s1_reg;
  logic       sck_s2_reg;
  logic       sck_s3_reg;
  logic       sdi_s1_reg;
  logic       sdi_s2_reg;
  logic [2:0] osc_cnt_reg;
  logic [2:0] tbc_cnt_reg;
  logic       tmr_tgl_reg;
  logic       tick;
  logic       sck_o_reg;
  logic       sdo_reg;
  logic [7:0] tx_sh_reg;
  logic [7:0] rx_sh_reg;
  logic [1:0] rx_tap_reg;
  logic [1:0] rx_end_reg;
  logic       rx_take;
  logic       rx_push;
  logic [2:0] bit_cnt_reg;
  logic [5:0] rem_reg;
  logic [1:0] gap_cnt_reg;
  logic       aw_full_reg;
  logic [3:0] aw_addr_reg;
  logic       w_full_reg;
  logic [7:0] w_data_reg;
  logic       w_stb_reg;
  logic       bvalid_reg;
  logic [1:0] bresp_reg;
  logic       rvalid_reg;
  logic [7:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic       port_rst;
  logic       wr_fire;
  logic       wr_ctrl;
  logic       wr_fcon;
  logic       wr_tx;
  logic       rd_fire;
  logic       start;
  logic       abort;
  logic       init;
  logic       port_clr;
  logic       fall_ev;
  logic       rise_ev;
  logic       byte_end;
  logic       done;
  logic       f_push;
  logic [7:0] f_wdata;
  logic       f_pop;
  logic [7:0] f_rdata;
  logic [5:0] f_count;
  logic       f_empty;
  logic       f_full;
  logic [7:0] fcon_rd;
  logic       wr_known;

  assign port_rst = !rst_n || core_reset_event;

  // Write side of the bus: address and data are latched in either order.
  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready  = !w_full_reg && !bvalid_reg;
  assign wr_fire       = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_ctrl       = wr_fire && w_stb_reg && aw_addr_reg == sfp_pkg::OFS_CTRL;
  assign wr_fcon       = wr_fire && w_stb_reg && aw_addr_reg == sfp_pkg::OFS_FCON;
  assign wr_tx         = wr_fire && w_stb_reg && aw_addr_reg == sfp_pkg::OFS_TX;
  assign wr_known      = aw_addr_reg == sfp_pkg::OFS_CTRL || aw_addr_reg == sfp_pkg::OFS_FCON
                      || aw_addr_reg == sfp_pkg::OFS_RX || aw_addr_reg == sfp_pkg::OFS_TX;
  assign ctl_wd        = sfp_pkg::sfp_ctrl_t'(w_data_reg);
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = {24'h000000, rdata_reg};
  assign rd_fire       = s_axi_arvalid && !rvalid_reg;

  // Write channel holding registers and the write response.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= sfp_pkg::RESP_OKAY;
      aw_addr_reg <= 4'h0;
      w_data_reg  <= 8'h00;
      w_stb_reg   <= 1'b0;
    end
    else if (wr_fire)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      bvalid_reg  <= 1'b1;
      bresp_reg   <= wr_known ? sfp_pkg::RESP_OKAY : sfp_pkg::RESP_SLV;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_stb_reg  <= s_axi_wstrb[0];
      end
      if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  assign ctrl_rd = '{one: 1'b1, busy: state_reg != sfp_pkg::ST_IDLE, ick: ick_reg,
                     ten: ten_reg, role: role_reg, src: src_reg};
  assign fcon_rd = {1'b0, companion_overrun_flag, companion_full_flag, companion_empty_flag,
                    1'b0, ovr_reg, f_full, f_empty};

  // Read channel; a receive read pops the head, so its data is registered.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 8'h00;
      rresp_reg  <= sfp_pkg::RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= sfp_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        sfp_pkg::OFS_CTRL: rdata_reg <= ctrl_rd;
        sfp_pkg::OFS_FCON: rdata_reg <= fcon_rd;
        sfp_pkg::OFS_RX:   rdata_reg <= f_rdata;
        sfp_pkg::OFS_TX:   rdata_reg <= 8'h00;
        default:
        begin
          rdata_reg <= 8'h00;
          rresp_reg <= sfp_pkg::RESP_SLV;
        end
      endcase
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  assign start    = wr_ctrl && ctl_wd.ten && state_reg == sfp_pkg::ST_IDLE;
  assign abort    = wr_ctrl && !ctl_wd.ten && state_reg != sfp_pkg::ST_IDLE;
  assign init     = wr_fcon && w_data_reg[sfp_pkg::F_INIT];
  assign port_clr = init || abort;
  assign byte_end = state_reg == sfp_pkg::ST_SHIFT && rise_ev && bit_cnt_reg == 3'h7;
  assign done     = (byte_end && rem_reg == 6'h01) || (start && f_count == 6'h00);

  // Control fields; bit 7 and the busy bit are never stored.
  always_ff @(posedge sys_clk)
  begin
    if (port_rst)
    begin
      src_reg  <= sfp_pkg::CTRL_RST[2:0];
      role_reg <= sfp_pkg::CTRL_RST[3];
      ten_reg  <= sfp_pkg::CTRL_RST[4];
      ick_reg  <= sfp_pkg::CTRL_RST[5];
    end
    else
    begin
      if (wr_ctrl)
      begin
        src_reg  <= ctl_wd.src;
        role_reg <= ctl_wd.role;
        ick_reg  <= ctl_wd.ick;
      end
      if (done || port_clr)
        ten_reg <= 1'b0;
      else if (wr_ctrl)
        ten_reg <= ctl_wd.ten;
    end
  end

  // Overrun and the completion pulses; a set beats an initialise.
  always_ff @(posedge sys_clk)
  begin
    if (port_rst)
    begin
      ovr_reg      <= sfp_pkg::FCON_RST[sfp_pkg::F_ORE];
      slv_done_reg <= 1'b0;
      done_reg     <= 1'b0;
      cinit_reg    <= 1'b0;
    end
    else
    begin
      if (role_reg && slv_done_reg && state_reg == sfp_pkg::ST_IDLE && fall_ev)
        ovr_reg <= 1'b1;
      else if (init)
        ovr_reg <= 1'b0;
      if (done && role_reg)
        slv_done_reg <= 1'b1;
      else if (start || port_clr)
        slv_done_reg <= 1'b0;
      done_reg  <= done;
      cinit_reg <= wr_fcon && w_data_reg[sfp_pkg::F_CINIT];
    end
  end
  assign xfer_done            = done_reg;
  assign companion_initialise = cinit_reg;

  // Pin synchronisers; only the second and third stages feed logic.
  always_ff @(posedge sys_clk)
  begin
    sck_s1_reg <= transfer_clock_pin_i;
    sck_s2_reg <= sck_s1_reg;
    sck_s3_reg <= sck_s2_reg;
    sdi_s1_reg <= serial_in_pin;
    sdi_s2_reg <= sdi_s1_reg;
  end

  // Prescalers for the master clock sources.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      osc_cnt_reg <= 3'h0;
      tbc_cnt_reg <= 3'h0;
      tmr_tgl_reg <= 1'b0;
    end
    else
    begin
      osc_cnt_reg <= osc_cnt_reg + 3'h1;
      if (tbc_tick)
        tbc_cnt_reg <= tbc_cnt_reg + 3'h1;
      if (tmr_ovf_tick)
        tmr_tgl_reg <= !tmr_tgl_reg;
    end
  end

  always_comb
  begin
    unique case (src_reg)
      3'h0: tick = 1'b1;
      3'h1: tick = osc_cnt_reg[0];
      3'h2: tick = &osc_cnt_reg[1:0];
      3'h3: tick = &osc_cnt_reg;
      3'h4: tick = tbc_tick && tbc_cnt_reg[0];
      3'h5: tick = tbc_tick && (&tbc_cnt_reg[1:0]);
      3'h6: tick = tbc_tick && (&tbc_cnt_reg);
      3'h7: tick = tmr_ovf_tick && tmr_tgl_reg;
    endcase
  end

  assign fall_ev = role_reg ? (!sck_s2_reg && sck_s3_reg) : (tick && sck_o_reg);
  assign rise_ev = role_reg ? (sck_s2_reg && !sck_s3_reg) : (tick && !sck_o_reg);

  // Sequencer of one exchange.
  always_ff @(posedge sys_clk)
  begin
    if (port_rst || port_clr)
      state_reg <= sfp_pkg::ST_IDLE;
    else
    begin
      unique case (state_reg)
        sfp_pkg::ST_IDLE:
          if (start && f_count != 6'h00)
            state_reg <= sfp_pkg::ST_LOAD;
        sfp_pkg::ST_LOAD:
          state_reg <= sfp_pkg::ST_SHIFT;
        sfp_pkg::ST_SHIFT:
          if (byte_end)
          begin
            if (rem_reg == 6'h01)
              state_reg <= sfp_pkg::ST_IDLE;
            else if (ick_reg && !role_reg)
              state_reg <= sfp_pkg::ST_GAP;
            else
              state_reg <= sfp_pkg::ST_LOAD;
          end
        sfp_pkg::ST_GAP:
          if (tick && gap_cnt_reg == sfp_pkg::GAP_HALVES - 2'h1)
            state_reg <= sfp_pkg::ST_LOAD;
      endcase
    end
  end

  // Byte counter and gap timer.
  always_ff @(posedge sys_clk)
  begin
    if (port_rst || port_clr)
    begin
      rem_reg     <= 6'h00;
      gap_cnt_reg <= 2'h0;
    end
    else
    begin
      if (start)
        rem_reg <= f_count;
      else if (byte_end)
        rem_reg <= rem_reg - 6'h01;
      if (byte_end)
        gap_cnt_reg <= 2'h0;
      else if (state_reg == sfp_pkg::ST_GAP && tick)
        gap_cnt_reg <= gap_cnt_reg + 2'h1;
    end
  end

  // Shifter and master clock; the idle clock level is high.
  always_ff @(posedge sys_clk)
  begin
    if (port_rst || port_clr)
    begin
      sck_o_reg   <= 1'b1;
      sdo_reg     <= 1'b1;
      tx_sh_reg   <= 8'h00;
      bit_cnt_reg <= 3'h0;
    end
    else if (state_reg == sfp_pkg::ST_LOAD)
    begin
      tx_sh_reg   <= f_rdata;
      bit_cnt_reg <= 3'h0;
    end
    else if (state_reg == sfp_pkg::ST_SHIFT)
    begin
      if (!role_reg && tick)
        sck_o_reg <= !sck_o_reg;
      if (fall_ev)
        sdo_reg <= tx_sh_reg[0];
      if (rise_ev)
      begin
        tx_sh_reg   <= {1'b0, tx_sh_reg[7:1]};
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
    end
    else
      sck_o_reg <= 1'b1;
  end

  // Receive capture. In master mode the reply to our own falling edge reaches us through the
  // two-stage synchroniser, so each bit is taken two cycles after the rising edge we drove.
  // The last byte of a master exchange therefore lands two cycles after the completion strobe.
  always_ff @(posedge sys_clk)
  begin
    if (port_rst || port_clr)
    begin
      rx_tap_reg <= 2'h0;
      rx_end_reg <= 2'h0;
      rx_sh_reg  <= 8'h00;
    end
    else
    begin
      rx_tap_reg <= {rx_tap_reg[0], state_reg == sfp_pkg::ST_SHIFT && rise_ev};
      rx_end_reg <= {rx_end_reg[0], byte_end};
      if (rx_take)
        rx_sh_reg <= {sdi_s2_reg, rx_sh_reg[7:1]};
    end
  end
  // A slave sees clock and data through equal delays, so it samples at once.
  assign rx_take = role_reg ? (state_reg == sfp_pkg::ST_SHIFT && rise_ev) : rx_tap_reg[1];
  assign rx_push = role_reg ? byte_end : rx_end_reg[1];

  assign f_push  = rx_push || wr_tx;
  assign f_wdata = rx_push ? {sdi_s2_reg, rx_sh_reg[7:1]} : w_data_reg;
  assign f_pop   = state_reg == sfp_pkg::ST_LOAD || (rd_fire && s_axi_araddr == sfp_pkg::OFS_RX);

  assign pins = '{transfer_clock_pin_o: sck_o_reg, transfer_clock_pin_oe: !role_reg,
                  serial_out_pin: sdo_reg};

  sfp_fifo u_fifo (
    .sys_clk (sys_clk),
    .rst_n   (!port_rst),
    .clr     (port_clr),
    .push    (f_push),
    .wdata   (f_wdata),
    .pop     (f_pop),
    .rdata   (f_rdata),
    .count   (f_count),
    .empty   (f_empty),
    .full    (f_full)
  );

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ctrl_top_a: assert property (rd_fire && s_axi_araddr == 4'h0 |=> s_axi_rdata[7])
    else $error("Control bit 7 read as zero.");
  ctrl_reset_a: assert property ($rose(rst_n) |-> ctrl_rd == sfp_pkg::CTRL_RST)
    else $error("Control not 80H after reset.");
  slave_clk_a: assert property (role_reg && $past(role_reg) |-> $stable(sck_o_reg))
    else $error("Slave toggled the clock output.");
  ten_clear_a: assert property (done |=> !ten_reg ##1 xfer_done == 1'b0)
    else $error("Enable not cleared at completion.");
  busy_start_a: assert property (start && f_count != 6'h00 |=> ctrl_rd.busy)
    else $error("Busy not shown after start.");
  overrun_set_a: assert property (role_reg && slv_done_reg && state_reg == sfp_pkg::ST_IDLE && fall_ev |=> ovr_reg)
    else $error("Overrun not flagged.");
  init_clear_a: assert property (init && !fall_ev |=> f_empty && !ovr_reg && !ctrl_rd.busy)
    else $error("Initialise did not clear the port.");
  done_pulse_a: assert property (xfer_done |-> !ten_reg && $past(rem_reg) <= 6'h01)
    else $error("Completion before last byte.");
  abort_stop_a: assert property (abort |=> state_reg == sfp_pkg::ST_IDLE && sck_o_reg)
    else $error("Abort did not stop the transfer.");

  master_xfer_c: cover property (!role_reg && byte_end ##[1:200] xfer_done);
  slave_xfer_c: cover property (role_reg && done);
  overrun_c: cover property (ovr_reg);
  gap_c: cover property (state_reg == sfp_pkg::ST_GAP);
endmodule
`default_nettype wire
